// file: csm_pkg.sv
// Package for the clock source select and drift monitor block
package csm_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;        // Reference clock period
  localparam real RC_NOM_MHZ = 18.432;      // RC and external nominal
  localparam real DET1_WIN_MS = 0.5;        // External clock window
  localparam real DET2_WIN_MS = 15.5;       // Crystal window
  localparam real AVG_WIN_MS = 64.0;        // Drift averaging window
  localparam int DET1_WIN_CYC = int'($floor(DET1_WIN_MS * 1.0E6 /
                                            CLK_PERIOD_NS));
  localparam int DET2_WIN_CYC = int'($floor(DET2_WIN_MS * 1.0E6 /
                                            CLK_PERIOD_NS));
  localparam int AVG_WIN_CYC = int'($floor(AVG_WIN_MS * 1.0E6 /
                                           CLK_PERIOD_NS));
  localparam int AVG_EXP_EDGES = int'($floor(AVG_WIN_MS * 1.0E3 *
                                             RC_NOM_MHZ));
  localparam int DET_MIN_PULSES = 256;      // Pulses that prove a clock
  localparam int DRIFT_PCT = 20;            // Threshold after reset
  localparam int PCT_FULL = 100;            // Percent scale
  localparam int SWITCH_GAP_CYC = 4;        // All gates off this plus one cycle

  // ----------------------------------------------------------------
  // Widths and encodings
  // ----------------------------------------------------------------
  localparam int CNT_W = 24;                // Window and edge counters
  localparam int MUL_W = 40;                // Threshold products
  localparam logic [1:0] SRC_RC = 2'h0;     // Internal RC oscillator
  localparam logic [1:0] SRC_RSVD = 2'h1;   // Reserved code, ignored
  localparam logic [1:0] SRC_EXT = 2'h2;    // External oscillator
  localparam logic [1:0] SRC_XTAL = 2'h3;   // External crystal
  localparam logic [2:0] GAP_W0 = 3'h0;     // Gap counter reset value

  // FSM states, Gray along detect, switch, run, check
  typedef enum logic [2:0] {
    ST_DET1 = 3'h0,
    ST_DET2 = 3'h1,
    ST_SWITCH = 3'h3,
    ST_RUN = 3'h2,
    ST_CHECK = 3'h6
  } csm_state_t;

  // Clock gate enables, one high at a time
  typedef struct packed {
    logic rc;
    logic ext;
    logic xtal;
  } csm_gates_t;

  // Whole block state
  typedef struct packed {
    logic pin_s1;                 // Synchroniser stage one
    logic pin_s2;                 // Synchroniser stage two
    logic pin_prev;               // Edge detect history
    csm_state_t st;               // Control state
    logic [CNT_W-1:0] win;        // Window cycle counter
    logic [CNT_W-1:0] edges;      // Pulses seen in window
    logic [1:0] field;            // Active clock source field
    logic [1:0] target;           // Source being switched to
    logic [2:0] gap;              // Break before make counter
    csm_gates_t gates;            // Clock gate enables
    logic xtal_amp;               // Crystal amplifier enable
    logic det_done;               // Detection done flag
    logic ready;                  // Device ready flag
    logic alarm;                  // Drift alarm status
    logic intr;                   // Drift interrupt flag
  } csm_reg_t;

endpackage

// file: csm_clock_select.sv
// Clock source selection, start-up detection and drift monitor
//
// Contract
// - Three sources: RC, crystal, external clock.
// - RC at 18.432 MHz is default.
// - Auto detection runs once after reset.
// - 256 pulses in 0.5 ms selects 2'b10.
// - Else 256 pulses in 15.5 ms selects 2'b11.
// - No detection keeps field at 2'b00.
// - Detection done set when phase one finds a source, else after both phases.
// - Ready rises only after detection done.
// - Software may select source afterwards.
// - Detected requested source updates status field.
// - Undetected requested source keeps old configuration.
// - External source enables continuous period monitoring.
// - Alarm when average difference exceeds 20 percent.
// - Averaging window is about 64 ms.
// - Alarm status bit readable by software.
// - Enabled alarm sets drift interrupt flag.
// - Ready flag tells software conversions may start.
`timescale 1ns/1ps
`default_nettype none

module csm_clock_select
  import csm_pkg::*;
#(
  parameter int DET1_CYC = DET1_WIN_CYC,   // Phase one window
  parameter int DET2_CYC = DET2_WIN_CYC,   // Phase two window
  parameter int AVG_CYC = AVG_WIN_CYC,     // Drift window
  parameter int AVG_EDGES = AVG_EXP_EDGES, // Nominal pulses per window
  parameter int MIN_PULSES = DET_MIN_PULSES
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Pin from crystal or oscillator
  input wire logic ext_clock_crystal_in_pin_in,
  // Software configuration
  input wire logic src_wr_in,
  input wire logic [1:0] clock_source_field_in,
  input wire logic ext_clock_drift_alarm_enable_in,
  input wire logic drift_int_clr_in,
  // Status
  output logic [1:0] clock_source_field_out,
  output logic detection_done_flag_out,
  output logic device_ready_out,
  output logic drift_alarm_status_out,
  output logic ext_clock_drift_interrupt_out,
  // Clock gate control
  output logic gate_rc_en_out,
  output logic gate_ext_en_out,
  output logic gate_xtal_en_out,
  output logic crystal_output_pin_en_out
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Window length of a given source check
  function automatic logic [CNT_W-1:0] win_len(input logic [1:0] src);
    if (src == SRC_EXT) begin
      win_len = CNT_W'(DET1_CYC);
    end else begin
      win_len = CNT_W'(DET2_CYC);
    end
  endfunction

  // Gate enable set that selects one source
  function automatic csm_gates_t gate_of(input logic [1:0] src);
    gate_of.rc = (src == SRC_RC);
    gate_of.ext = (src == SRC_EXT);
    gate_of.xtal = (src == SRC_XTAL);
  endfunction

  // True when the source is one of the external ones
  function automatic logic is_ext(input logic [1:0] src);
    is_ext = (src == SRC_EXT) || (src == SRC_XTAL);
  endfunction

  // Average count off nominal by more than the threshold
  function automatic logic drifted(input logic [CNT_W-1:0] cnt);
    logic [CNT_W-1:0] nom;
    logic [CNT_W-1:0] diff;
    nom = CNT_W'(AVG_EDGES);
    diff = (cnt > nom) ? (cnt - nom) : (nom - cnt);
    drifted = (MUL_W'(diff) * MUL_W'(PCT_FULL)) >
              (MUL_W'(nom) * MUL_W'(DRIFT_PCT));
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  csm_reg_t r_q;      // Registered state
  csm_reg_t r_d;      // Next state
  logic pin_rise;     // Synchronised rising edge
  logic win_end;      // Window counter expired
  logic enough;       // Pulse target reached

  // Rising edge from synchronised pin only
  assign pin_rise = r_q.pin_s2 & ~r_q.pin_prev;
  assign win_end = (r_q.win == '0);
  assign enough = (r_q.edges >= CNT_W'(MIN_PULSES));

  // ----------------------------------------------------------------
  // Next state logic
  // ----------------------------------------------------------------
  always_comb begin
    r_d = r_q;
    // Two stage pin synchroniser, reference domain
    r_d.pin_s1 = ext_clock_crystal_in_pin_in;
    r_d.pin_s2 = r_q.pin_s1;
    r_d.pin_prev = r_q.pin_s2;
    // Window counter and pulse counter, timed by the reference
    if (!win_end) begin
      r_d.win = r_q.win - CNT_W'(1);
    end
    if (pin_rise && (r_q.edges != '1)) begin
      r_d.edges = r_q.edges + CNT_W'(1);
    end
    // Drift interrupt clear; a new event below wins
    if (drift_int_clr_in) begin
      r_d.intr = 1'b0;
    end
    unique case (r_q.st)
      // Phase one: external oscillator present
      ST_DET1: begin
        if (enough) begin
          r_d.target = SRC_EXT;
          r_d.det_done = 1'b1;
          r_d.xtal_amp = 1'b0;
          r_d.gap = GAP_W0;
          r_d.gates = '0;
          r_d.st = ST_SWITCH;
        end else if (win_end) begin
          // Start phase two with crystal amplifier on
          r_d.win = CNT_W'(DET2_CYC);
          r_d.edges = '0;
          r_d.xtal_amp = 1'b1;
          r_d.st = ST_DET2;
        end
      end
      // Phase two: crystal installed
      ST_DET2: begin
        if (enough || win_end) begin
          r_d.det_done = 1'b1;
          r_d.target = enough ? SRC_XTAL : SRC_RC;
          r_d.xtal_amp = enough;
          r_d.gap = GAP_W0;
          r_d.gates = '0;
          r_d.st = ST_SWITCH;
        end
      end
      // All gates off for a gap, then the new one on
      ST_SWITCH: begin
        if (r_q.gap == 3'(SWITCH_GAP_CYC)) begin
          r_d.gates = gate_of(r_q.target);
          r_d.field = r_q.target;
          r_d.ready = r_q.det_done;
          r_d.win = CNT_W'(AVG_CYC);
          r_d.edges = '0;
          r_d.st = ST_RUN;
        end else begin
          r_d.gap = r_q.gap + 3'(1);
        end
      end
      // Running; monitor drift and take software requests
      ST_RUN: begin
        if (is_ext(r_q.field) && win_end) begin
          r_d.alarm = drifted(r_q.edges);
          if (drifted(r_q.edges) && ext_clock_drift_alarm_enable_in) begin
            r_d.intr = 1'b1;
          end
          r_d.win = CNT_W'(AVG_CYC);
          r_d.edges = '0;
        end
        if (src_wr_in && (clock_source_field_in != SRC_RSVD) &&
            (clock_source_field_in != r_q.field)) begin
          r_d.target = clock_source_field_in;
          if (clock_source_field_in == SRC_RC) begin
            // RC needs no check
            r_d.gap = GAP_W0;
            r_d.gates = '0;
            r_d.alarm = 1'b0;
            r_d.xtal_amp = 1'b0;
            r_d.st = ST_SWITCH;
          end else begin
            r_d.win = win_len(clock_source_field_in);
            r_d.edges = '0;
            r_d.xtal_amp = (clock_source_field_in == SRC_XTAL) ||
                           (r_q.field == SRC_XTAL);
            r_d.st = ST_CHECK;
          end
        end
      end
      // Check requested external source before switching
      ST_CHECK: begin
        if (enough) begin
          r_d.gap = GAP_W0;
          r_d.gates = '0;
          r_d.alarm = 1'b0;
          r_d.xtal_amp = (r_q.target == SRC_XTAL);
          r_d.st = ST_SWITCH;
        end else if (win_end) begin
          // Not detected: keep everything as it was
          r_d.target = r_q.field;
          r_d.xtal_amp = (r_q.field == SRC_XTAL);
          r_d.win = CNT_W'(AVG_CYC);
          r_d.edges = '0;
          r_d.st = ST_RUN;
        end
      end
      default: begin
        r_d.st = ST_RUN;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      // Reset starts the one-time detection on RC
      r_q <= '0;
      r_q.st <= ST_DET1;
      r_q.win <= CNT_W'(DET1_CYC);
      r_q.field <= SRC_RC;
      r_q.target <= SRC_RC;
      r_q.gates <= '{rc: 1'b1, ext: 1'b0, xtal: 1'b0};
    end else begin
      r_q <= r_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs straight from state
  // ----------------------------------------------------------------
  assign clock_source_field_out = r_q.field;
  assign detection_done_flag_out = r_q.det_done;
  assign device_ready_out = r_q.ready;
  assign drift_alarm_status_out = r_q.alarm;
  assign ext_clock_drift_interrupt_out = r_q.intr;
  assign gate_rc_en_out = r_q.gates.rc;
  assign gate_ext_en_out = r_q.gates.ext;
  assign gate_xtal_en_out = r_q.gates.xtal;
  assign crystal_output_pin_en_out = r_q.xtal_amp;

endmodule

`default_nettype wire

// file: csm_pin_model.sv
// Partner model: oscillator or crystal driving the shared input pin
`timescale 1ns/1ps
`default_nettype none

module csm_pin_model (
  // Half period in ns, zero means no source fitted
  input wire logic [7:0] half_ns_in,
  // Pin towards the block
  output logic pin_out
);
  // ------------------------------------------------------------
  // Oscillator
  // ------------------------------------------------------------
  // No source: pin stands still low, never a stale toggle
  initial begin
    pin_out = 1'b0;
    forever begin
      if (half_ns_in == 8'h00) begin
        pin_out = 1'b0;
        #7;
      end else begin
        #(half_ns_in) pin_out = ~pin_out;
      end
    end
  end
endmodule
`default_nettype wire

// file: csm_clock_select_props.sv
// Checker for the clock source select and drift monitor
`timescale 1ns/1ps
`default_nettype none

module csm_clock_select_props (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Inputs
  input wire logic ext_clock_crystal_in_pin_in,
  input wire logic src_wr_in,
  input wire logic [1:0] clock_source_field_in,
  input wire logic ext_clock_drift_alarm_enable_in,
  input wire logic drift_int_clr_in,
  // Outputs
  input wire logic [1:0] clock_source_field_out,
  input wire logic detection_done_flag_out,
  input wire logic device_ready_out,
  input wire logic drift_alarm_status_out,
  input wire logic ext_clock_drift_interrupt_out,
  input wire logic gate_rc_en_out,
  input wire logic gate_ext_en_out,
  input wire logic gate_xtal_en_out,
  input wire logic crystal_output_pin_en_out
);
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  wire logic [2:0] g = {gate_rc_en_out, gate_ext_en_out, gate_xtal_en_out};

  AST_GATE_ONEHOT: assert property ($onehot0(g))
    else $error("more than one clock gate on");
  AST_GAP: assert property ($fell(g != 3'h0) |-> (g == 3'h0) [*4])
    else $error("switch gap shorter than four cycles");
  AST_FIELD_AFTER_GAP: assert property ($changed(clock_source_field_out)
    |-> $past(g) == 3'h0)
    else $error("field changed without a gap");
  AST_FIELD_CODE: assert property (clock_source_field_out != 2'h1)
    else $error("reserved source code shown");
  AST_DONE_STICKY: assert property (detection_done_flag_out
    |=> detection_done_flag_out)
    else $error("done flag dropped");
  AST_READY_AFTER_DONE: assert property (device_ready_out
    |-> detection_done_flag_out)
    else $error("ready without done");
  AST_ALARM_EXT: assert property ($rose(drift_alarm_status_out)
    |-> clock_source_field_out[1])
    else $error("alarm with internal source");
  AST_INT_EXT: assert property ($rose(ext_clock_drift_interrupt_out)
    |-> clock_source_field_out[1] && drift_alarm_status_out)
    else $error("interrupt without external alarm");
  AST_INT_STICKY: assert property (ext_clock_drift_interrupt_out
    && !drift_int_clr_in |=> ext_clock_drift_interrupt_out)
    else $error("interrupt dropped without clear");
endmodule

bind csm_clock_select csm_clock_select_props u_props (.*);
`default_nettype wire

// file: tb.sv
// Self-checking testbench for the clock source select block
`timescale 1ns/1ps
`default_nettype none

module tb;
  import csm_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic mclk_in = 1'b0, rst_n_in = 1'b0, wr = 1'b0, en = 1'b0, clr = 1'b0;
  logic [1:0] sel = 2'h0, fld;
  logic [7:0] half = 8'h00;
  logic pin, done, rdy, alm, intr, g_rc, g_ext, g_xt;
  int miscompares = 0, n_compared = 0;

  always #5 mclk_in = ~mclk_in;

  csm_pin_model u_pin (.half_ns_in(half), .pin_out(pin));

  csm_clock_select #(.DET1_CYC(400), .DET2_CYC(1000), .AVG_CYC(2000),
    .AVG_EDGES(200), .MIN_PULSES(16)) dut (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .ext_clock_crystal_in_pin_in(pin), .src_wr_in(wr), .clock_source_field_in(sel),
    .ext_clock_drift_alarm_enable_in(en), .drift_int_clr_in(clr),
    .clock_source_field_out(fld), .detection_done_flag_out(done),
    .device_ready_out(rdy), .drift_alarm_status_out(alm),
    .ext_clock_drift_interrupt_out(intr), .gate_rc_en_out(g_rc),
    .gate_ext_en_out(g_ext), .gate_xtal_en_out(g_xt),
    .crystal_output_pin_en_out());

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Compare with case equality
  task chk(input logic [2:0] got, input logic [2:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // Counts and verdict
  task summarize;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Bounded wait for a field value
  task wait_fld(input logic [1:0] f, input int lim);
    int i;
    for (i = 0; i < lim && fld !== f; i++) @(posedge mclk_in);
    if (i == lim) begin
      chk(fld, f, "timeout");
      summarize;
    end
  endtask

  // Reset with a given source fitted, then wait for ready
  task do_reset(input logic [7:0] h);
    int i;
    half = h;
    @(posedge mclk_in) rst_n_in <= 1'b0;
    repeat (8) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    for (i = 0; i < 3000 && rdy !== 1'b1; i++) @(posedge mclk_in);
    if (i == 3000) begin
      chk(rdy, 1'b1, "ready timeout");
      summarize;
    end
    repeat (2) @(posedge mclk_in);
  endtask

  // One-cycle source write
  task sw(input logic [1:0] s);
    @(posedge mclk_in) wr <= 1'b1;
    sel <= s;
    @(posedge mclk_in) wr <= 1'b0;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  // Start-up detection for each kind of source
  task t_auto;
    do_reset(8'h32);
    chk(fld, SRC_EXT, "auto ext");
    chk({g_rc, g_ext, g_xt}, 3'h2, "ext gate");
    do_reset(8'hC8);
    chk(fld, SRC_XTAL, "auto xtal");
    chk(done, 1'b1, "done");
    do_reset(8'h00);
    chk(fld, SRC_RC, "auto none");
    chk({g_rc, g_ext, g_xt}, 3'h4, "rc gate");
    half = 8'h32;
    repeat (1500) @(posedge mclk_in);
    chk(fld, SRC_RC, "detect once");
  endtask

  // Software selection, found and missing sources
  task t_sw;
    sw(SRC_RSVD);
    repeat (20) @(posedge mclk_in);
    chk(fld, SRC_RC, "reserved ignored");
    sw(SRC_EXT);
    wait_fld(SRC_EXT, 600);
    chk({g_rc, g_ext, g_xt}, 3'h2, "sw ext gate");
    half = 8'h00;
    sw(SRC_XTAL);
    repeat (1200) @(posedge mclk_in);
    chk(fld, SRC_EXT, "missing kept");
    sw(SRC_RC);
    wait_fld(SRC_RC, 20);
    chk({g_rc, g_ext, g_xt}, 3'h4, "back to rc");
  endtask

  // Drift alarm and interrupt over averaging windows
  task t_drift;
    do_reset(8'h32);
    en <= 1'b1;
    repeat (4200) @(posedge mclk_in);
    chk({alm, intr}, 2'h0, "nominal");
    half = 8'h46;
    repeat (4200) @(posedge mclk_in);
    chk({alm, intr}, 2'h3, "drift");
    half = 8'h32;
    repeat (4200) @(posedge mclk_in);
    chk({alm, intr}, 2'h1, "alarm gone, flag kept");
    @(posedge mclk_in) clr <= 1'b1;
    @(posedge mclk_in) clr <= 1'b0;
    @(posedge mclk_in);
    chk(intr, 1'b0, "cleared");
  endtask

  initial begin
    t_auto;
    t_sw;
    t_drift;
    summarize;
  end
endmodule
`default_nettype wire
